// >>> logic/awt_watchdog_thresholds.sv
// Converter sequencer with watchdog windows behind an APB slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module awt_watchdog_thresholds
  import awt_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Converter core
  input wire logic CORE_READY_IN,
  input wire logic CORE_SAMPLED_IN,
  input wire logic CORE_DONE_IN,
  input wire logic [11:0] CORE_DATA_IN,
  output logic CORE_START_OUT,
  output logic [4:0] CORE_CHANNEL_OUT,
  // Triggers
  input wire logic REG_TRIG_IN,
  input wire logic INJ_TRIG_IN,
  // Status
  output logic REGULAR_CONV_RUNNING_OUT,
  output logic INJECTED_CONV_RUNNING_OUT,
  output logic IRQ_OUT
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] wd1_ff;
  logic [31:0] wd2_ff;
  logic [31:0] wd3_ff;
  logic [31:0] cfg_ff;
  logic [31:0] wdcfg_ff;
  logic [NUM_EVT-1:0] status_ff;
  logic [NUM_EVT-1:0] mask_ff;
  logic [NUM_EVT-1:0] nxt_status;
  logic [NUM_EVT-1:0] evt;
  logic irq_ff;
  logic regular_conv_running_ff;
  logic injected_conv_running_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [11:0] data_ff;
  logic [11:0] inj_data_ff;
  logic data_valid_ff;
  logic core_ready_d_ff;
  awt_state_t state_ff;
  awt_state_t nxt_state;
  logic [3:0] seq_idx_ff;
  logic [3:0] nxt_seq_idx;
  logic cur_inj_ff;
  logic nxt_cur_inj;
  logic resume_ff;
  logic nxt_resume;
  logic core_start_ff;
  logic nxt_core_start;
  logic [4:0] core_ch_ff;
  logic [4:0] nxt_core_ch;
  logic [4:0] conv_ch_ff;
  logic [2:0] awd_hit;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic thr_sel;
  logic thr_locked;
  logic [31:0] rd_mux;

  assign access = PSEL_IN & PENABLE_IN;
  // Completion edge is the one where pready is already high
  assign done = access & pready_ff;
  assign wr_done = done & PWRITE_IN;
  assign rd_done = done & ~PWRITE_IN;
  assign thr_sel = (PADDR_IN == OFS_WD1) | (PADDR_IN == OFS_WD2) |
                   (PADDR_IN == OFS_WD3);
  // Threshold changes mid-conversion would race the comparators
  assign thr_locked = regular_conv_running_ff |
                      injected_conv_running_ff;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR_IN)
      OFS_CTRL:
      begin
        rd_mux[CTRL_REG_START] = regular_conv_running_ff;
        rd_mux[CTRL_INJ_START] = injected_conv_running_ff;
      end
      OFS_STAT: rd_mux[NUM_EVT-1:0] = status_ff;
      OFS_MASK: rd_mux[NUM_EVT-1:0] = mask_ff;
      OFS_CFG: rd_mux = cfg_ff;
      OFS_WDCFG: rd_mux = wdcfg_ff;
      OFS_DATA:
      begin
        rd_mux[11:0] = data_ff;
        rd_mux[DATA_INJ_LSB +: 12] = inj_data_ff;
      end
      OFS_WD1: rd_mux = wd1_ff;
      OFS_WD2: rd_mux = wd2_ff;
      OFS_WD3: rd_mux = wd3_ff;
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: answer is prepared before pready rises
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= access & ~pready_ff;
      if (access & ~pready_ff)
      begin
        prdata_ff <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
        pslverr_ff <= ~mapped | (PWRITE_IN & thr_sel & thr_locked);
      end
      else
      begin
        prdata_ff <= 32'h0000_0000;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Threshold and configuration registers
  // ************************************************************
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      wd1_ff <= RST_WD1;
      wd2_ff <= RST_WD2;
      wd3_ff <= RST_WD3;
    end
    else if (wr_done && !thr_locked)
    begin
      // Reserved bits are never stored and read as zero
      if (PADDR_IN == OFS_WD1)
        wd1_ff <= PWDATA_IN & WD1_KEEP;
      if (PADDR_IN == OFS_WD2)
        wd2_ff <= PWDATA_IN & WD8_KEEP;
      if (PADDR_IN == OFS_WD3)
        wd3_ff <= PWDATA_IN & WD8_KEEP;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      cfg_ff <= RST_CFG;
      wdcfg_ff <= RST_WDCFG;
      mask_ff <= '0;
    end
    else if (wr_done)
    begin
      if (PADDR_IN == OFS_CFG)
        cfg_ff <= PWDATA_IN & 32'h001f_3f1f;
      if (PADDR_IN == OFS_WDCFG)
        wdcfg_ff <= PWDATA_IN & 32'h007f_7f7f;
      if (PADDR_IN == OFS_MASK)
        mask_ff <= PWDATA_IN[NUM_EVT-1:0];
    end
  end

  // ************************************************************
  // Run flags
  // ************************************************************
  logic inj_finish;

  assign inj_finish = (state_ff == ST_CONVERT) & cur_inj_ff & CORE_DONE_IN;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      regular_conv_running_ff <= 1'b0;
      injected_conv_running_ff <= 1'b0;
    end
    else
    begin
      if (wr_done && PADDR_IN == OFS_CTRL && PWDATA_IN[CTRL_REG_START])
        regular_conv_running_ff <= 1'b1;
      else if (wr_done && PADDR_IN == OFS_CTRL &&
               PWDATA_IN[CTRL_REG_STOP])
        regular_conv_running_ff <= 1'b0;
      // A new software start wins over the hardware finish
      if (wr_done && PADDR_IN == OFS_CTRL && PWDATA_IN[CTRL_INJ_START])
        injected_conv_running_ff <= 1'b1;
      else if (inj_finish)
        injected_conv_running_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  logic [4:0] first_ch;
  logic [3:0] seq_len;
  logic [4:0] inj_ch;
  logic last_in_seq;

  assign first_ch = cfg_ff[CFG_FIRST_LSB +: 5];
  assign seq_len = cfg_ff[CFG_LEN_LSB +: 4];
  assign inj_ch = cfg_ff[CFG_INJ_LSB +: 5];
  // Without scan only the first channel is converted
  assign last_in_seq = ~cfg_ff[CFG_SCAN] | (seq_idx_ff == seq_len);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_seq_idx = seq_idx_ff;
    nxt_cur_inj = cur_inj_ff;
    nxt_resume = resume_ff;
    nxt_core_start = 1'b0;
    nxt_core_ch = core_ch_ff;
    evt = '0;
    case (state_ff)
      ST_IDLE, ST_NEXT:
      begin
        // Injected trigger has priority over the regular sequence
        if (injected_conv_running_ff && INJ_TRIG_IN)
        begin
          nxt_core_start = 1'b1;
          nxt_core_ch = inj_ch;
          nxt_cur_inj = 1'b1;
          nxt_resume = (state_ff == ST_NEXT);
          nxt_state = ST_CONVERT;
        end
        else if (regular_conv_running_ff &&
                 (state_ff == ST_NEXT || REG_TRIG_IN))
        begin
          nxt_core_start = 1'b1;
          if (state_ff == ST_IDLE)
            nxt_seq_idx = 4'h0;
          nxt_core_ch = (state_ff == ST_IDLE) ? first_ch :
                        5'(first_ch + {1'b0, seq_idx_ff});
          nxt_cur_inj = 1'b0;
          nxt_state = ST_CONVERT;
        end
        else if (!regular_conv_running_ff)
          nxt_state = ST_IDLE;
      end
      ST_CONVERT:
      begin
        evt[EV_EOSMP] = CORE_SAMPLED_IN;
        if (CORE_DONE_IN)
        begin
          if (cur_inj_ff)
          begin
            evt[EV_JEOC] = 1'b1;
            evt[EV_JEOS] = 1'b1;
            nxt_state = (resume_ff && regular_conv_running_ff) ?
                        ST_NEXT : ST_IDLE;
            nxt_resume = 1'b0;
          end
          else
          begin
            evt[EV_EOC] = 1'b1;
            if (last_in_seq)
            begin
              evt[EV_EOS] = 1'b1;
              nxt_seq_idx = 4'h0;
              // Continuous restarts at once; single waits for a trigger
              nxt_state = cfg_ff[CFG_CONT] ? ST_NEXT : ST_IDLE;
            end
            else
            begin
              nxt_seq_idx = 4'(seq_idx_ff + 4'h1);
              nxt_state = ST_NEXT;
            end
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (state_ff == ST_CONVERT && CORE_DONE_IN && !cur_inj_ff)
      evt[EV_OVR] = data_valid_ff &
                    ~(rd_done & (PADDR_IN == OFS_DATA));
    evt[EV_RDY] = CORE_READY_IN & ~core_ready_d_ff;
    evt[EV_AWD1] = awd_hit[0];
    evt[EV_AWD2] = awd_hit[1];
    evt[EV_AWD3] = awd_hit[2];
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      state_ff <= ST_IDLE;
      seq_idx_ff <= 4'h0;
      cur_inj_ff <= 1'b0;
      resume_ff <= 1'b0;
      core_start_ff <= 1'b0;
      core_ch_ff <= 5'h00;
      conv_ch_ff <= 5'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      seq_idx_ff <= nxt_seq_idx;
      cur_inj_ff <= nxt_cur_inj;
      resume_ff <= nxt_resume;
      core_start_ff <= nxt_core_start;
      core_ch_ff <= nxt_core_ch;
      if (nxt_core_start)
        conv_ch_ff <= nxt_core_ch;
    end
  end

  // ************************************************************
  // Results
  // ************************************************************
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      data_ff <= 12'h000;
      inj_data_ff <= 12'h000;
      data_valid_ff <= 1'b0;
      core_ready_d_ff <= 1'b0;
    end
    else
    begin
      core_ready_d_ff <= CORE_READY_IN;
      if (state_ff == ST_CONVERT && CORE_DONE_IN && cur_inj_ff)
        inj_data_ff <= CORE_DATA_IN;
      // New result wins over a read in the same cycle
      if (state_ff == ST_CONVERT && CORE_DONE_IN && !cur_inj_ff)
      begin
        data_ff <= CORE_DATA_IN;
        data_valid_ff <= 1'b1;
      end
      else if (rd_done && PADDR_IN == OFS_DATA)
        data_valid_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Watchdogs
  // ************************************************************
  logic res_valid;

  assign res_valid = (state_ff == ST_CONVERT) & CORE_DONE_IN;

  awt_window_check #(.TW(12)) u_wd_one
  (
    .res_valid_in(res_valid),
    .res_data_in(CORE_DATA_IN),
    .res_ch_in(conv_ch_ff),
    .upper_in(wd1_ff[WD_UP_LSB +: 12]),
    .lower_in(wd1_ff[11:0]),
    .guard_in(wdcfg_ff[0 +: WDCFG_STRIDE]),
    .hit_out(awd_hit[0])
  );

  awt_window_check #(.TW(8)) u_wd_two
  (
    .res_valid_in(res_valid),
    .res_data_in(CORE_DATA_IN),
    .res_ch_in(conv_ch_ff),
    .upper_in(wd2_ff[WD_UP_LSB +: 8]),
    .lower_in(wd2_ff[7:0]),
    .guard_in(wdcfg_ff[WDCFG_STRIDE +: WDCFG_STRIDE]),
    .hit_out(awd_hit[1])
  );

  awt_window_check #(.TW(8)) u_wd_three
  (
    .res_valid_in(res_valid),
    .res_data_in(CORE_DATA_IN),
    .res_ch_in(conv_ch_ff),
    .upper_in(wd3_ff[WD_UP_LSB +: 8]),
    .lower_in(wd3_ff[7:0]),
    .guard_in(wdcfg_ff[2*WDCFG_STRIDE +: WDCFG_STRIDE]),
    .hit_out(awd_hit[2])
  );

  // ************************************************************
  // Interrupt status
  // ************************************************************
  always_comb
  begin
    nxt_status = status_ff;
    if (rd_done && PADDR_IN == OFS_STAT)
      nxt_status = '0;
    // Set after clear so an event in the read cycle survives
    nxt_status = nxt_status | evt;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign PRDATA_OUT = prdata_ff;
  assign PREADY_OUT = pready_ff;
  assign PSLVERR_OUT = pslverr_ff;
  assign CORE_START_OUT = core_start_ff;
  assign CORE_CHANNEL_OUT = core_ch_ff;
  assign REGULAR_CONV_RUNNING_OUT = regular_conv_running_ff;
  assign INJECTED_CONV_RUNNING_OUT = injected_conv_running_ff;
  assign IRQ_OUT = irq_ff;

endmodule

// >>> pkg/awt_pkg.sv
// Constants and types for the converter watchdog threshold block
// Operation
// - Watchdog one upper limit sits in 27:16
// - Watchdog one lower limit sits in 11:0
// - Watchdog two window at 0x24, reset 0x00ff0000
// - Single converts once per trigger; continuous repeats
// - Convert one channel or scan a sequence
// - Interrupts on ready, sampling, conversions, watchdogs, overrun
package awt_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0c;
  localparam logic [7:0] OFS_WDCFG = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [7:0] OFS_WD1 = 8'h20;
  localparam logic [7:0] OFS_WD2 = 8'h24;
  localparam logic [7:0] OFS_WD3 = 8'h28;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RST_WD1 = 32'h0fff_0000;
  localparam logic [31:0] RST_WD2 = 32'h00ff_0000;
  localparam logic [31:0] RST_WD3 = 32'h00ff_0000;
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_WDCFG = 32'h0000_0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_REG_START = 0;
  localparam int CTRL_INJ_START = 1;
  localparam int CTRL_REG_STOP = 2;
  localparam int CFG_FIRST_LSB = 0;
  localparam int CFG_LEN_LSB = 8;
  localparam int CFG_CONT = 12;
  localparam int CFG_SCAN = 13;
  localparam int CFG_INJ_LSB = 16;
  localparam int WD_UP_LSB = 16;
  localparam int WDCFG_STRIDE = 8;
  localparam int WDCFG_ALL = 5;
  localparam int WDCFG_EN = 6;
  localparam int DATA_INJ_LSB = 16;
  localparam logic [31:0] WD1_KEEP = 32'h0fff_0fff;
  localparam logic [31:0] WD8_KEEP = 32'h00ff_00ff;

  // ************************************************************
  // Event bits of status and mask
  // ************************************************************
  localparam int NUM_EVT = 10;
  localparam int EV_RDY = 0;
  localparam int EV_EOSMP = 1;
  localparam int EV_EOC = 2;
  localparam int EV_JEOC = 3;
  localparam int EV_EOS = 4;
  localparam int EV_JEOS = 5;
  localparam int EV_AWD1 = 6;
  localparam int EV_AWD2 = 7;
  localparam int EV_AWD3 = 8;
  localparam int EV_OVR = 9;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_CONVERT,
    ST_NEXT
  } awt_state_t;

endpackage

// >>> logic/awt_window_check.sv
// Window comparison for one analog watchdog
`timescale 1ns/1ps
module awt_window_check
  import awt_pkg::*;
#(
  parameter int TW = 12
)
(
  // Result under test
  input wire logic res_valid_in,
  input wire logic [11:0] res_data_in,
  input wire logic [4:0] res_ch_in,
  // Window and guard
  input wire logic [TW-1:0] upper_in,
  input wire logic [TW-1:0] lower_in,
  input wire logic [7:0] guard_in,
  // Verdict
  output logic hit_out
);

  logic [TW-1:0] res_top;
  logic guarded;

  // Narrow windows look at the top bits only
  assign res_top = res_data_in[11 -: TW];
  assign guarded = guard_in[WDCFG_EN] &
                   (guard_in[WDCFG_ALL] | (guard_in[4:0] == res_ch_in));
  assign hit_out = res_valid_in & guarded &
                   ((res_top > upper_in) | (res_top < lower_in));

endmodule

// >>> testbench/awt_watchdog_thresholds_props.sv
// Bus and sequencer checks for the watchdog threshold block
`timescale 1ns/1ps
module awt_watchdog_thresholds_props
(
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Converter side
  input wire logic CORE_START_OUT,
  input wire logic [4:0] CORE_CHANNEL_OUT,
  input wire logic REGULAR_CONV_RUNNING_OUT,
  input wire logic INJECTED_CONV_RUNNING_OUT,
  input wire logic IRQ_OUT
);
  // ************************************************************
  // Helpers
  // ************************************************************
  logic acc_wait;
  logic wd_addr;
  logic mapped;
  assign acc_wait = PSEL_IN && PENABLE_IN && !PREADY_OUT;
  assign wd_addr = PADDR_IN inside {8'h20, 8'h24, 8'h28};
  assign mapped = wd_addr ||
    (PADDR_IN inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14});
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // ************************************************************
  // Properties
  // ************************************************************
  property p_one_wait;
    acc_wait |=> PREADY_OUT;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("late pready");
  property p_ready_pulse;
    PREADY_OUT |=> !PREADY_OUT;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
  property p_idle_data;
    !PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("stray prdata");
  property p_err_with_ready;
    PSLVERR_OUT |-> PREADY_OUT;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("stray pslverr");
  property p_unmapped;
    acc_wait && !mapped |=> PSLVERR_OUT;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped no error");
  property p_mapped_read;
    acc_wait && mapped && !PWRITE_IN |=> !PSLVERR_OUT;
  endproperty
  a_mapped_read: assert property (p_mapped_read) else $error("read error");
  // Run flag sampled on both cycles, so a flag edge cannot make it ambiguous
  property p_wd_refused;
    acc_wait && PWRITE_IN && wd_addr && REGULAR_CONV_RUNNING_OUT
      ##1 REGULAR_CONV_RUNNING_OUT |-> PSLVERR_OUT;
  endproperty
  a_wd_refused: assert property (p_wd_refused)
    else $error("threshold write while running");
  property p_run_set;
    PREADY_OUT && PSEL_IN && PWRITE_IN && PADDR_IN == 8'h00 && PWDATA_IN[0]
      |=> REGULAR_CONV_RUNNING_OUT;
  endproperty
  a_run_set: assert property (p_run_set) else $error("run flag not set");
  property p_start_pulse;
    CORE_START_OUT |=> !CORE_START_OUT;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("long start");
  property p_start_cause;
    CORE_START_OUT |->
      $past(REGULAR_CONV_RUNNING_OUT || INJECTED_CONV_RUNNING_OUT);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start while stopped");
  property p_chan_hold;
    !CORE_START_OUT |-> $stable(CORE_CHANNEL_OUT);
  endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel moved");
  c_start: cover property (CORE_START_OUT);
  c_err: cover property (PSLVERR_OUT);
  c_irq: cover property ($rose(IRQ_OUT));
endmodule

bind awt_watchdog_thresholds awt_watchdog_thresholds_props u_props
(
  .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .CORE_START_OUT(CORE_START_OUT),
  .CORE_CHANNEL_OUT(CORE_CHANNEL_OUT),
  .REGULAR_CONV_RUNNING_OUT(REGULAR_CONV_RUNNING_OUT),
  .INJECTED_CONV_RUNNING_OUT(INJECTED_CONV_RUNNING_OUT), .IRQ_OUT(IRQ_OUT)
);

// >>> testbench/awt_watchdog_thresholds_bench.sv
// Self-checking bench for the watchdog threshold block
`timescale 1ns/1ps
module awt_watchdog_thresholds_bench;
  import awt_pkg::*;
  typedef struct packed
  {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
  } awt_row_t;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic rdy = 1'b0, smp = 1'b0, done = 1'b0, rtrig = 1'b0, itrig = 1'b0;
  logic [11:0] cdata = 12'h000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, start, run_r, run_i, irq, er;
  logic [4:0] chan;
  int mismatches = 0, samples_checked = 0, i;
  // Reserved bits written as zero, top byte of window two on purpose
  awt_row_t rows [8] = '{
    '{1'b0, OFS_WD1, 32'h0, 32'h0fff_0000, 1'b0},
    '{1'b0, OFS_WD2, 32'h0, 32'h00ff_0000, 1'b0},
    '{1'b1, OFS_WD1, 32'h0abc_0123, 32'h0, 1'b0},
    '{1'b0, OFS_WD1, 32'h0, 32'h0abc_0123, 1'b0},
    '{1'b1, OFS_WD2, 32'hff5a_00a5, 32'h0, 1'b0},
    '{1'b0, OFS_WD2, 32'h0, 32'h005a_00a5, 1'b0},
    '{1'b1, 8'h18, 32'h1, 32'h0, 1'b1},
    '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1}};

  always #4 clk = ~clk;

  awt_watchdog_thresholds uut
  (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CORE_READY_IN(rdy), .CORE_SAMPLED_IN(smp),
    .CORE_DONE_IN(done), .CORE_DATA_IN(cdata), .CORE_START_OUT(start),
    .CORE_CHANNEL_OUT(chan), .REG_TRIG_IN(rtrig), .INJ_TRIG_IN(itrig),
    .REGULAR_CONV_RUNNING_OUT(run_r), .INJECTED_CONV_RUNNING_OUT(run_i),
    .IRQ_OUT(irq)
  );
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic hang(input string nm);
    chk(nm, 32'h1, 32'h0);
    summarize();
  endtask

  // Enters on a fresh edge so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40)
      hang("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conv(input logic [4:0] ch, input logic [11:0] d);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (start !== 1'b1 && n < 200);
    if (n >= 200)
      hang("start");
    chk("channel", {27'h0, ch}, {27'h0, chan});
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
    cdata <= d;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdy <= 1'b1;
    foreach (rows[k])
    begin
      apb(rows[k].wr, rows[k].addr, rows[k].wdata, rd, er);
      chk("rdata", rows[k].rdata, rd);
      chk("pslverr", {31'h0, rows[k].err}, {31'h0, er});
    end
    $display("register table test done");
    apb(1'b1, OFS_WD1, 32'h0800_0100, rd, er);
    apb(1'b1, OFS_WDCFG, 32'h0000_0060, rd, er);
    apb(1'b1, OFS_MASK, 32'h0000_0044, rd, er);
    apb(1'b1, OFS_CFG, 32'h0000_0005, rd, er);
    apb(1'b1, OFS_CTRL, 32'h0000_0001, rd, er);
    apb(1'b1, OFS_WD1, 32'h0123_0456, rd, er);
    chk("refused", 32'h1, {31'h0, er});
    @(posedge clk);
    rtrig <= 1'b1;
    @(posedge clk);
    rtrig <= 1'b0;
    conv(5'd5, 12'hfff);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, OFS_STAT, 32'h0, rd, er);
    chk("status", 32'h0000_0057, rd);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, OFS_WD1, 32'h0, rd, er);
    chk("kept", 32'h0800_0100, rd);
    apb(1'b0, OFS_DATA, 32'h0, rd, er);
    chk("data", 32'h0000_0fff, rd);
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      chk("no_restart", 32'h0, {31'h0, start});
    end
    $display("single watchdog test done");
    apb(1'b1, OFS_CTRL, 32'h0000_0004, rd, er);
    apb(1'b1, OFS_CFG, 32'h0000_3103, rd, er);
    apb(1'b1, OFS_CTRL, 32'h0000_0001, rd, er);
    @(posedge clk);
    rtrig <= 1'b1;
    @(posedge clk);
    rtrig <= 1'b0;
    // One trigger, four results: continuous scan wraps on its own
    for (i = 0; i < 4; i++)
      conv(i[0] ? 5'd4 : 5'd3, 12'h200);
    apb(1'b1, OFS_CTRL, 32'h0000_0004, rd, er);
    apb(1'b0, OFS_STAT, 32'h0, rd, er);
    chk("status", 32'h0000_0216, rd);
    $display("scan test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_WD1, 32'h0, rd, er);
    chk("reset", 32'h0fff_0000, rd);
    chk("run", 32'h0, {30'h0, run_i, run_r});
    $display("reset test done");
    // Injected path: one conversion, then its run flag drops by itself
    apb(1'b1, OFS_CTRL, 32'h0000_0002, rd, er);
    apb(1'b0, OFS_CTRL, 32'h0, rd, er);
    chk("inj_run", 32'h0000_0002, rd);
    @(posedge clk);
    itrig <= 1'b1;
    @(posedge clk);
    itrig <= 1'b0;
    conv(5'd0, 12'h3c5);
    apb(1'b0, OFS_CTRL, 32'h0, rd, er);
    chk("inj_done", 32'h0, rd);
    apb(1'b0, OFS_STAT, 32'h0, rd, er);
    chk("status", 32'h0000_002b, rd);
    apb(1'b0, OFS_DATA, 32'h0, rd, er);
    chk("inj_data", 32'h03c5_0000, rd);
    $display("injected test done");
    summarize();
  end
endmodule
